// ### logic/qp_pkg.sv
package qp_pkg;
    // ------------------------------------------------------------
    // port geometry
    // ------------------------------------------------------------
    localparam int        QP_PORT_W   = 8;
    localparam int        QP_NPORT    = 4;
    localparam int        QP_LINES    = QP_PORT_W * QP_NPORT;
    localparam logic [7:0] QP_PORT_RST = 8'hFF;
    localparam int        QP_P0_LSB   = 0;
    localparam int        QP_P1_LSB   = 8;
    localparam int        QP_P2_LSB   = 16;
    localparam int        QP_P3_LSB   = 24;
    // ------------------------------------------------------------
    // alternate function line positions (flat 32-line index)
    // ------------------------------------------------------------
    localparam int QP_T2_CNT  = 8;
    localparam int QP_T2_RLD  = 9;
    localparam int QP_SER1_RX = 10;
    localparam int QP_SER1_TX = 11;
    localparam int QP_IRQ2    = 12;
    localparam int QP_IRQ3    = 13;
    localparam int QP_IRQ4    = 14;
    localparam int QP_IRQ5    = 15;
    localparam int QP_SER0_RX = 24;
    localparam int QP_SER0_TX = 25;
    localparam int QP_WR_N    = 30;
    localparam int QP_RD_N    = 31;
    // ------------------------------------------------------------
    // external bus cycle
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        QP_IDLE = 2'h0,
        QP_ADDR = 2'h1,
        QP_DATA = 2'h3,
        QP_DONE = 2'h2
    } qp_state_t;
endpackage : qp_pkg

// ### logic/qp_ports.sv
`timescale 1ns/1ps
module qp_ports (
    // clock and reset
    input  wire logic                    i_clock,
    input  wire logic                    i_rst,
    // port register writes
    input  wire logic [3:0]              i_port_wr,
    input  wire logic [7:0]              i_port_wdata,
    output logic [qp_pkg::QP_LINES-1:0]  o_pin_state,
    // pads
    input  wire logic [qp_pkg::QP_LINES-1:0] i_pad_in,
    output logic [qp_pkg::QP_LINES-1:0]  o_pad_out,
    output logic [qp_pkg::QP_LINES-1:0]  o_pad_oe,
    output logic [qp_pkg::QP_LINES-1:0]  o_pullup_en,
    // configuration
    input  wire logic [qp_pkg::QP_LINES-1:0] i_port_direction_config,
    input  wire logic                    i_xmem_en,
    input  wire logic                    i_ext_memory_port_select,
    input  wire logic                    i_fetch_ext,
    // external data move
    input  wire logic                    i_xmove_req,
    input  wire logic                    i_xmove_wr,
    input  wire logic                    i_xmove_data_pointer,
    input  wire logic [7:0]              i_xaddr_lo,
    input  wire logic [7:0]              i_data_pointer_hi,
    input  wire logic [7:0]              i_external_page_register,
    input  wire logic [7:0]              i_xwdata,
    // external code fetch
    input  wire logic                    i_fetch_req,
    input  wire logic [15:0]             i_fetch_addr,
    // bus results
    output logic                         o_bus_done,
    output logic [7:0]                   o_bus_rdata,
    output logic                         o_ale,
    output logic                         o_psen_n,
    // timer two
    input  wire logic                    i_timer_two_counter_select,
    input  wire logic                    i_timer_two_autoreload,
    input  wire logic                    i_timer_two_ext_enable,
    input  wire logic                    i_t2_flag_clr,
    output logic                         o_t2_count,
    output logic                         o_t2_reload,
    output logic                         o_timer_two_external_flag,
    // serial ports and SPI
    input  wire logic                    i_ser1_en,
    input  wire logic                    i_secondary_serial_tx,
    output logic                         o_secondary_serial_rx,
    input  wire logic                    i_ser0_en,
    input  wire logic                    i_primary_serial_tx,
    output logic                         o_primary_serial_rx,
    input  wire logic                    i_spi_miso_en,
    input  wire logic                    i_spi_miso,
    // external interrupt events 2..5
    output logic [3:0]                   o_irq_evt
);
    import qp_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [QP_LINES-1:0] port_r;
    logic [QP_LINES-1:0] s1_r;
    logic [QP_LINES-1:0] s2_r;
    logic [QP_LINES-1:0] s3_r;
    qp_state_t           st_r;
    qp_state_t           st_nxt;
    logic                fetch_r;
    logic                wr_r;
    logic [7:0]          lo_r;
    logic [7:0]          hi_r;
    logic [7:0]          wd_r;
    logic [7:0]          rdata_r;
    logic                flag_r;
    logic                cnt_r;
    logic                rld_r;
    logic [3:0]          irq_r;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire                busy       = (st_r != QP_IDLE);
    wire                in_addr    = (st_r == QP_ADDR);
    wire                in_data    = (st_r == QP_DATA);
    wire                start_f    = i_fetch_ext && i_fetch_req;
    wire                start_m    = i_xmem_en && i_xmove_req && !start_f;
    wire [QP_LINES-1:0] rise       = s2_r & ~s3_r;
    wire [QP_LINES-1:0] fall       = s3_r & ~s2_r;
    wire                rld_ev     = i_timer_two_autoreload && i_timer_two_ext_enable
                                     && fall[QP_T2_RLD];
    wire [7:0]          mv_hi      = i_xmove_data_pointer ? i_data_pointer_hi
                                                  : i_external_page_register;
    wire                p0_own     = busy || i_fetch_ext;
    wire                p2_own     = i_ext_memory_port_select;
    wire                strb_own   = i_ext_memory_port_select && i_xmem_en;
    wire [7:0]          p0_val     = in_addr ? lo_r : wd_r;
    wire                p0_oe      = in_addr || (in_data && wr_r && !fetch_r);
    wire                wr_strb_n  = !(in_data && wr_r && !fetch_r);
    wire                rd_strb_n  = !(in_data && !wr_r && !fetch_r);

    // ownership, value and enable of the alternate function per line
    logic [QP_LINES-1:0] own_w;
    logic [QP_LINES-1:0] aval_w;
    logic [QP_LINES-1:0] aoe_w;

    always_comb begin
        own_w  = '0;
        aval_w = '0;
        aoe_w  = '0;
        own_w[QP_P0_LSB +: QP_PORT_W]  = {QP_PORT_W{p0_own}};
        aval_w[QP_P0_LSB +: QP_PORT_W] = p0_val;
        aoe_w[QP_P0_LSB +: QP_PORT_W]  = {QP_PORT_W{p0_oe}};
        own_w[QP_P2_LSB +: QP_PORT_W]  = {QP_PORT_W{p2_own}};
        aval_w[QP_P2_LSB +: QP_PORT_W] = hi_r;
        aoe_w[QP_P2_LSB +: QP_PORT_W]  = {QP_PORT_W{p2_own}};
        own_w[QP_SER1_TX]  = i_ser1_en;
        aval_w[QP_SER1_TX] = i_secondary_serial_tx;
        aoe_w[QP_SER1_TX]  = i_ser1_en;
        own_w[QP_IRQ4]     = i_spi_miso_en;
        aval_w[QP_IRQ4]    = i_spi_miso;
        aoe_w[QP_IRQ4]     = i_spi_miso_en;
        own_w[QP_SER0_TX]  = i_ser0_en;
        aval_w[QP_SER0_TX] = i_primary_serial_tx;
        aoe_w[QP_SER0_TX]  = i_ser0_en;
        own_w[QP_WR_N]     = strb_own;
        aval_w[QP_WR_N]    = wr_strb_n;
        aoe_w[QP_WR_N]     = strb_own;
        own_w[QP_RD_N]     = strb_own;
        aval_w[QP_RD_N]    = rd_strb_n;
        aoe_w[QP_RD_N]     = strb_own;
    end

    // ------------------------------------------------------------
    // pad drive
    // ------------------------------------------------------------
    // register drives line unless an alternate function owns it
    assign o_pad_out   = (own_w & aval_w) | (~own_w & port_r);
    // register-driven quasi-bidirectional lines only pull low, push-pull lines push both ways; owned lines use the alternate enable
    assign o_pad_oe    = (own_w & aoe_w)
                       | (~own_w & (~i_port_direction_config | ~port_r));
    assign o_pullup_en = i_port_direction_config & ~own_w
                       & {QP_LINES{!busy && !i_fetch_ext}};

    assign o_pin_state            = s2_r;
    assign o_bus_done             = (st_r == QP_DONE);
    assign o_bus_rdata            = rdata_r;
    assign o_ale                  = in_addr;
    assign o_psen_n               = !(in_data && fetch_r);
    assign o_t2_count             = cnt_r;
    assign o_t2_reload            = rld_r;
    assign o_timer_two_external_flag = flag_r;
    assign o_secondary_serial_rx  = s2_r[QP_SER1_RX];
    assign o_primary_serial_rx    = s2_r[QP_SER0_RX];
    assign o_irq_evt              = irq_r;

    // ------------------------------------------------------------
    // bus cycle sequencer
    // ------------------------------------------------------------
    always_comb begin
        case (st_r)
            QP_IDLE: st_nxt = (start_f || start_m) ? QP_ADDR : QP_IDLE;
            QP_ADDR: st_nxt = QP_DATA;
            QP_DATA: st_nxt = QP_DONE;
            QP_DONE: st_nxt = QP_IDLE;
            default: st_nxt = QP_IDLE;
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st_r    <= QP_IDLE;
            fetch_r <= 1'b0;
            wr_r    <= 1'b0;
            lo_r    <= '0;
            hi_r    <= '0;
            wd_r    <= '0;
            rdata_r <= '0;
        end else begin
            st_r <= st_nxt;
            if (!busy && start_f) begin
                fetch_r <= 1'b1;
                wr_r    <= 1'b0;
                lo_r    <= i_fetch_addr[7:0];
                hi_r    <= i_fetch_addr[15:8];
            end else if (!busy && start_m) begin
                fetch_r <= 1'b0;
                wr_r    <= i_xmove_wr;
                lo_r    <= i_xaddr_lo;
                hi_r    <= mv_hi;
                wd_r    <= i_xwdata;
            end
            // data sampled while the strobe is low
            if (in_data && !wr_r) begin
                rdata_r <= i_pad_in[QP_P0_LSB +: QP_PORT_W];
            end
        end
    end

    // ------------------------------------------------------------
    // port registers and input sampling
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            port_r <= {QP_NPORT{QP_PORT_RST}};
            s1_r   <= '1;
            s2_r   <= '1;
            s3_r   <= '1;
        end else begin
            for (int p = 0; p < QP_NPORT; p++) begin
                if (i_port_wr[p]) begin
                    port_r[p*QP_PORT_W +: QP_PORT_W] <= i_port_wdata;
                end
            end
            s1_r <= i_pad_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // ------------------------------------------------------------
    // pin events
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cnt_r  <= 1'b0;
            rld_r  <= 1'b0;
            flag_r <= 1'b0;
            irq_r  <= '0;
        end else begin
            cnt_r  <= i_timer_two_counter_select && fall[QP_T2_CNT];
            rld_r  <= rld_ev;
            flag_r <= rld_ev || (flag_r && !i_t2_flag_clr);
            irq_r  <= {fall[QP_IRQ5], rise[QP_IRQ4], fall[QP_IRQ3], rise[QP_IRQ2]};
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    property p_rd_state;
        ##2 o_pin_state == $past(i_pad_in, 2);
    endproperty
    a_rd_state: assert property (p_rd_state) else $error("pin state not 2-stage input");
    property p_wr_port1;
        i_port_wr[1] |=> (own_w[15:8] != 0) || (o_pad_out[15:8] == $past(i_port_wdata));
    endproperty
    a_wr_port1: assert property (p_wr_port1) else $error("port one not driven");
    property p_pullup_std;
        (o_pullup_en & ~i_port_direction_config) == '0;
    endproperty
    a_pullup_std: assert property (p_pullup_std) else $error("pull-up off-mode");
    property p_pullup_bus;
        busy |-> o_pullup_en == '0;
    endproperty
    a_pullup_bus: assert property (p_pullup_bus) else $error("pull-up during access");
    property p_move_seq;
        (!busy && start_m) |=> o_ale && o_pad_out[7:0] == $past(i_xaddr_lo)
                               ##1 !o_ale ##1 o_bus_done;
    endproperty
    a_move_seq: assert property (p_move_seq) else $error("move sequence wrong");
    property p_p2_gate;
        !i_ext_memory_port_select |-> own_w[23:16] == '0;
    endproperty
    a_p2_gate: assert property (p_p2_gate) else $error("port two taken");
    property p_wr_strobe;
        (in_data && wr_r && !fetch_r && strb_own) |-> !o_pad_out[QP_WR_N] && o_pad_oe[QP_WR_N];
    endproperty
    a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe missing");
    property p_rd_strobe;
        (strb_own && !(in_data && !wr_r && !fetch_r)) |-> o_pad_out[QP_RD_N];
    endproperty
    a_rd_strobe: assert property (p_rd_strobe) else $error("stray read strobe");
    property p_count;
        (i_timer_two_counter_select && s3_r[QP_T2_CNT] && !s2_r[QP_T2_CNT]) |=> o_t2_count;
    endproperty
    a_count: assert property (p_count) else $error("count edge lost");
    property p_flag;
        rld_ev |=> o_timer_two_external_flag && o_t2_reload;
    endproperty
    a_flag: assert property (p_flag) else $error("reload flag not set");
    property p_irq2;
        (s2_r[QP_IRQ2] && !s3_r[QP_IRQ2]) |=> o_irq_evt[0];
    endproperty
    a_irq2: assert property (p_irq2) else $error("irq two edge lost");
    c_move_wr: cover property ((!busy && start_m && i_xmove_wr) ##3 o_bus_done);
    c_move_rd: cover property ((!busy && start_m && !i_xmove_wr) ##3 o_bus_done);
    c_fetch:   cover property ((!busy && start_f) ##2 !o_psen_n);
    c_irq5:    cover property (o_irq_evt[3]);
endmodule : qp_ports

// ### sim/qp_xmem_model.sv
`timescale 1ns/1ps
module qp_xmem_model (
    // clock
    input  wire logic        i_clock,
    // device pads
    input  wire logic [31:0] i_pad_out,
    input  wire logic [31:0] i_pad_oe,
    input  wire logic [31:0] i_pullup_en,
    input  wire logic        i_ale,
    input  wire logic        i_psen_n,
    // bench drive
    input  wire logic [31:0] i_tb_val,
    input  wire logic [31:0] i_tb_en,
    // resolved line levels
    output logic [31:0]      o_pad
);
    logic [7:0] mem [256];
    logic [7:0] lo_r;
    logic       flt_r = 1'b0;
    logic       rd_drv;
    logic       wr_stb;
    assign rd_drv = ~i_psen_n | (i_pad_oe[31] & ~i_pad_out[31]);
    assign wr_stb = i_pad_oe[30] & ~i_pad_out[30];
    always_ff @(posedge i_clock) begin
        flt_r <= ~flt_r;
        if (i_ale) begin
            lo_r <= i_pad_out[7:0];
        end
        if (wr_stb) begin
            mem[lo_r] <= i_pad_out[7:0];
        end
    end
    // released lines not driven by memory or the bench float to a toggling level unless pulled up
    always_comb begin
        for (int k = 0; k < 32; k++) begin
            o_pad[k] = i_pad_oe[k] ? i_pad_out[k] :
                       (rd_drv && k < 8) ? mem[lo_r][k[2:0]] :
                       i_tb_en[k] ? i_tb_val[k] :
                       i_pullup_en[k] ? 1'b1 : flt_r;
        end
    end
endmodule : qp_xmem_model

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
    import qp_pkg::*;
    logic        i_clock = 1'b0;
    logic        i_rst = 1'b1;
    logic [3:0]  i_port_wr = 4'h0;
    logic [7:0]  i_port_wdata = 8'h00;
    logic [31:0] cfg = 32'hFFFFFFFF;
    logic        xmem = 1'b0, sel = 1'b0, fext = 1'b0, mreq = 1'b0, mwr = 1'b0, mdp = 1'b0;
    logic [7:0]  alo = 8'h00, dph = 8'h00, pg = 8'h00, wd = 8'h00;
    logic        freq = 1'b0, t2c = 1'b0, t2a = 1'b0, t2e = 1'b0, fclr = 1'b0;
    logic        s1en = 1'b0, s1tx = 1'b1, s0en = 1'b0, s0tx = 1'b1;
    logic        men = 1'b0, mso = 1'b0;
    logic [15:0] faddr = 16'h0000;
    logic [31:0] tb_val = 32'h0, tb_en = 32'h0, pin, pout, poe, pu, pad;
    logic [7:0]  rdata;
    logic [3:0]  irq;
    logic        done, ale, psen_n, t2cnt, t2rld, t2f, rx1, rx0;
    int          bad_count = 0;
    int          comparisons = 0;
    always #12.5 i_clock = ~i_clock;
    qp_ports uut (.i_clock(i_clock), .i_rst(i_rst), .i_port_wr(i_port_wr),
        .i_port_wdata(i_port_wdata), .o_pin_state(pin), .i_pad_in(pad), .o_pad_out(pout),
        .o_pad_oe(poe), .o_pullup_en(pu), .i_port_direction_config(cfg), .i_xmem_en(xmem),
        .i_ext_memory_port_select(sel), .i_fetch_ext(fext), .i_xmove_req(mreq),
        .i_xmove_wr(mwr), .i_xmove_data_pointer(mdp), .i_xaddr_lo(alo), .i_data_pointer_hi(dph),
        .i_external_page_register(pg), .i_xwdata(wd), .i_fetch_req(freq),
        .i_fetch_addr(faddr), .o_bus_done(done), .o_bus_rdata(rdata), .o_ale(ale),
        .o_psen_n(psen_n), .i_timer_two_counter_select(t2c), .i_timer_two_autoreload(t2a),
        .i_timer_two_ext_enable(t2e), .i_t2_flag_clr(fclr), .o_t2_count(t2cnt),
        .o_t2_reload(t2rld), .o_timer_two_external_flag(t2f), .i_ser1_en(s1en),
        .i_secondary_serial_tx(s1tx), .o_secondary_serial_rx(rx1), .i_ser0_en(s0en),
        .i_primary_serial_tx(s0tx), .o_primary_serial_rx(rx0), .i_spi_miso_en(men),
        .i_spi_miso(mso), .o_irq_evt(irq));
    qp_xmem_model mem0 (.i_clock(i_clock), .i_pad_out(pout), .i_pad_oe(poe),
        .i_pullup_en(pu), .i_ale(ale), .i_psen_n(psen_n), .i_tb_val(tb_val),
        .i_tb_en(tb_en), .o_pad(pad));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic tick(input int n = 1);
        repeat (n) @(posedge i_clock);
        #2;
    endtask : tick
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    task automatic bus_walk(input logic f, input logic [7:0] lo, hi, d);
        if (f) freq = 1'b1;
        else mreq = 1'b1;
        tick();
        freq = 1'b0;
        mreq = 1'b0;
        chk("ale", ale, 1);
        chk("port0 addr", pout[7:0], lo);
        chk("port2 addr", pout[23:16], hi);
        chk("p0 pullup", pu[7:0], 0);
        tick();
        chk("psen", psen_n, !f);
        chk("wr strobe", pout[QP_WR_N], !(mwr && !f));
        chk("rd strobe", pout[QP_RD_N], mwr || f);
        if (mwr && !f) chk("port0 data", pout[7:0], d);
        tick();
        chk("done", done, 1);
        if (!mwr || f) chk("rdata", rdata, d);
        tick();
    endtask : bus_walk
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk("reset pads", pout, 32'hFFFFFFFF);
        chk("reset pullups", pu, 32'hFFFFFFFF);
        chk("reset flag", t2f, 0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_ports;
        i_port_wr = 4'h2;
        i_port_wdata = 8'h5A;
        tick();
        i_port_wr = 4'h0;
        tick();
        chk("port1 out", pout[15:8], 8'h5A);
        tick(2);
        chk("port1 read", pin[15:8], 8'h5A);
        cfg[15:8] = 8'h00;
        tick();
        chk("pushpull pullup", pu[15:8], 0);
        chk("pushpull oe", poe[15:8], 8'hFF);
        cfg[15:8] = 8'hFF;
        i_port_wr = 4'h2;
        i_port_wdata = 8'hFF;
        tick();
        i_port_wr = 4'h0;
        tick(3);
        $display("test ports done");
    endtask : t_ports
    task automatic t_xmem;
        xmem = 1'b1;
        sel = 1'b1;
        {mwr, mdp, alo, dph, pg, wd} = {2'b11, 8'h34, 8'h12, 8'h56, 8'hA5};
        tick();
        bus_walk(1'b0, 8'h34, 8'h12, 8'hA5);
        {mwr, mdp} = 2'b00;
        bus_walk(1'b0, 8'h34, 8'h56, 8'hA5);
        $display("test external move done");
    endtask : t_xmem
    task automatic t_fetch;
        fext = 1'b1;
        faddr = 16'h1234;
        tick();
        chk("fetch pullup", pu[7:0], 0);
        bus_walk(1'b1, 8'h34, 8'h12, 8'hA5);
        fext = 1'b0;
        $display("test fetch done");
    endtask : t_fetch
    task automatic t_edges;
        int ln [6] = '{8, 9, 12, 13, 14, 15};
        logic ac [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        int sl [6] = '{4, 5, 0, 1, 2, 3};
        int n;
        logic [5:0] ev;
        {t2c, t2a, t2e} = 3'b111;
        for (int i = 0; i < 6; i++) begin
            tb_en[ln[i]] = 1'b1;
            tb_val[ln[i]] = ~ac[i];
            tick(8);
            n = 0;
            tb_val[ln[i]] = ac[i];
            repeat (8) begin
                tick();
                ev = {t2rld, t2cnt, irq};
                n += ev[sl[i]];
            end
            chk("active edge", n, 1);
            n = 0;
            tb_val[ln[i]] = ~ac[i];
            repeat (8) begin
                tick();
                ev = {t2rld, t2cnt, irq};
                n += ev[sl[i]];
            end
            chk("idle edge", n, 0);
            tb_en[ln[i]] = 1'b0;
            tick(8);
        end
        chk("reload flag", t2f, 1);
        fclr = 1'b1;
        tick();
        fclr = 1'b0;
        tick();
        chk("flag clear", t2f, 0);
        $display("test edges done");
    endtask : t_edges
    task automatic t_serial;
        {s1en, s1tx, s0en, s0tx} = 4'b1011;
        tb_en[QP_SER1_RX] = 1'b1;
        tb_en[QP_SER0_RX] = 1'b1;
        tb_val[QP_SER1_RX] = 1'b0;
        tb_val[QP_SER0_RX] = 1'b0;
        i_port_wr = 4'h8;
        i_port_wdata = 8'hFD;
        tick();
        i_port_wr = 4'h0;
        tick(3);
        chk("tx1 line", pout[QP_SER1_TX], 0);
        chk("tx0 line", pout[QP_SER0_TX], 1);
        chk("rx1", rx1, 0);
        chk("rx0", rx0, 0);
        {s1tx, s0tx} = 2'b10;
        tick();
        chk("tx lines", {pout[QP_SER1_TX], pout[QP_SER0_TX]}, 2'b10);
        {men, mso} = 2'b10;
        tick();
        chk("miso line", {poe[QP_IRQ4], pout[QP_IRQ4]}, 2'b10);
        men = 1'b0;
        tick();
        $display("test serial done");
    endtask : t_serial
    initial begin
        tick(16);
        i_rst = 1'b0;
        tick();
        t_reset();
        t_ports();
        t_xmem();
        t_fetch();
        t_edges();
        t_serial();
        close_out();
    end
    initial begin
        repeat (3000) @(posedge i_clock);
        bad_count++;
        close_out();
    end
endmodule : tb
